// ---- design/oas_pkg.sv ----
// oas_pkg: constants, state enum and carrier structs for the operand address sequencer.
// assumes one synchronous memory port with a one-cycle read latency.
//
// Contract
// - service pending interrupt: acknowledge, read device address, load vector or move byte.
// - memory reference picks address mode from sub op code, uses bytes two and three.
// - direct page zero loads second byte unchanged into operand address.
// - direct relative adds second byte to program counter.
// - indirect page zero fetches word; bit 15 set means add index.
// - indirect relative fetches word at pc plus byte; bit 15 set means add index.
// - indexed mode copies index register to operand address.
// - indexed with bias adds second byte to index register.
// - extended mode uses bytes two and three, indexed when bit 15 set.
// - literal mode increments pc and uses it as operand address.
// - non-memory instructions skip operand address formation.
// - memory reference accesses operand at operand address register.
// - bootstrap entered only from cold start, loads loader from paper tape.
// - sixteen working files allocated flags, instr, index, acc, ext, opaddr, pc, temps, ovw.
// - temporary file c always holds subroutine return address; the code loads dispatch bases and serial shift bits into it.
// - modified commands take file and operation from modifier register.
// - modifier constants encode copy, and, subtract, add, copy index and store codes.
// - main dispatch shifts op code right four, masks, jumps into table at 100.
// - conditional jump and control dispatch use their own base constants.
// - jump to next location is a two clock timing filler.
// - shift-in-one shifts file c right, inserts one, writes file and modifier.
// - serial timing nests inner, outer and bit counters, shifting a bit per bit time.
// - relative displacement added to pc of the following instruction.
// - word length bit set loads two consecutive bytes from operand address; the code loads two when bit 3 is clear, one when set.
// - serial input fills low accumulator byte, keeps high byte, ends on whole char.
package oas_pkg;
   // ----------------------------------------
   // working file numbers
   // ----------------------------------------
   // working file map
   localparam logic [3:0] FILE_FLAGS = 4'h0;
   localparam logic [3:0] FILE_INSTR = 4'h1;
   localparam logic [3:0] FILE_XL = 4'h2;
   localparam logic [3:0] FILE_XU = 4'h3;
   localparam logic [3:0] FILE_AL = 4'h4;
   localparam logic [3:0] FILE_AU = 4'h5;
   localparam logic [3:0] FILE_BL = 4'h6;
   localparam logic [3:0] FILE_BU = 4'h7;
   localparam logic [3:0] FILE_OL = 4'h8;
   localparam logic [3:0] FILE_OU = 4'h9;
   localparam logic [3:0] FILE_PL = 4'hA;
   localparam logic [3:0] FILE_PU = 4'hB;
   localparam logic [3:0] FILE_S1 = 4'hC;
   localparam logic [3:0] FILE_S2 = 4'hD;
   localparam logic [3:0] FILE_S3 = 4'hE;
   localparam logic [3:0] FILE_OVW = 4'hF;
   // ----------------------------------------
   // modifier constants
   // ----------------------------------------
   localparam logic [7:0] COPY_TO_ACC_CODE = 8'hB4;
   localparam logic [7:0] AND_ACC_CODE = 8'hC4;
   localparam logic [7:0] SUB_ACC_CODE = 8'h94;
   localparam logic [7:0] ADD_ACC_CODE = 8'h84;
   localparam logic [7:0] COPY_TO_INDEX_CODE = 8'hB2;
   localparam logic [7:0] STORE_ACC_CODE = 8'hA4;
   localparam logic [7:0] STORE_INDEX_CODE = 8'hA2;
   localparam logic [7:0] STORE_EXT_ACC_CODE = 8'hA6;
   // ----------------------------------------
   // dispatch constants
   // ----------------------------------------
   localparam logic [7:0] MAIN_DISPATCH_BASE = 8'h10;
   localparam logic [7:0] COND_JUMP_BASE = 8'h4E;
   localparam logic [7:0] CONTROL_DISPATCH_BASE = 8'h15;
   localparam logic [11:0] MAIN_TABLE_LOC = 12'h100;
   // ----------------------------------------
   // op code fields
   // ----------------------------------------
   localparam int OP_HI = 7;
   localparam int OP_LO = 4;
   localparam int WIDTH_BIT = 3;
   localparam int INDEX_FLAG_BIT = 15;
   localparam logic [3:0] OP_MEMREF_MIN = 4'h6;
   localparam logic [3:0] OP_CONDJ = 4'h1;
   localparam logic [3:0] OP_SERIAL_IO = 4'h3;
   localparam logic [7:0] OP_SERIAL_IN = 8'h30;
   localparam logic [2:0] MODE_DIR_PAGE0 = 3'h0;
   localparam logic [2:0] MODE_DIR_REL = 3'h1;
   localparam logic [2:0] MODE_IND_PAGE0 = 3'h2;
   localparam logic [2:0] MODE_IND_REL = 3'h3;
   localparam logic [2:0] MODE_INDEXED = 3'h4;
   localparam logic [2:0] MODE_INDEX_BIAS = 3'h5;
   localparam logic [2:0] MODE_EXTENDED = 3'h6;
   localparam logic [2:0] MODE_LITERAL = 3'h7;
   // ----------------------------------------
   // timing and reset values
   // ----------------------------------------
   localparam logic [7:0] INNER_COUNT = 8'hFF;
   localparam logic [7:0] OUTER_COUNT = 8'h0E;
   localparam logic [3:0] CHAR_BITS = 4'h8;
   localparam logic [15:0] COLD_START_PC = 16'h0000;
   localparam int FILLER_CLOCKS = 2;

   typedef enum logic [4:0] {
      OAS_COLD, OAS_BOOT, OAS_FETCH, OAS_FETCH_WAIT, OAS_DECODE, OAS_IRQ_ACK, OAS_IRQ_VEC, OAS_IRQ_CIO,
      OAS_BYTE2, OAS_BYTE3, OAS_IND_LO, OAS_IND_HI, OAS_INDEX, OAS_OPER_LO, OAS_OPER_HI, OAS_STORE,
      OAS_NONMEM, OAS_SER_INNER, OAS_SER_OUTER, OAS_SER_BIT, OAS_FILLER, OAS_RET
   } oas_state_t;

   typedef struct packed {
      logic req;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } oas_mem_req_t;

   typedef struct packed {
      logic pending;
      logic external;
      logic concurrent;
      logic [7:0] dev_addr;
      logic [7:0] data;
   } oas_irq_t;

   typedef struct packed {
      oas_state_t st;
      logic [15:0][7:0] files;
      logic [7:0] modifier;
      logic [7:0] dispatch;
      logic [7:0] inner;
      logic [7:0] outer;
      logic [3:0] bits;
      logic [15:0] indirect;
      logic phase;
      logic filler;
      oas_mem_req_t mem;
      logic irq_ack;
      logic cio_strobe;
      logic [7:0] cio_data;
      logic tape_req;
   } oas_regs_t;
endpackage

// ---- design/oas_sequencer.sv ----
// oas_sequencer: fetch, interrupt service, operand addressing and serial timing.
// assumes memory read data valid the cycle after a read request, and synchronous inputs.
module oas_sequencer (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic cold_start,
   input wire logic boot_switch,
   input wire oas_pkg::oas_irq_t irq_in,
   input wire logic [7:0] mem_rdata,
   input wire logic serial_rx,
   output oas_pkg::oas_mem_req_t mem_out,
   output logic irq_ack,
   output logic cio_strobe,
   output logic [7:0] cio_data,
   output logic tape_req,
   output logic [15:0] pc,
   output logic [15:0] opaddr,
   output logic [15:0] accum,
   output logic [15:0] index,
   output logic [7:0] modifier,
   output logic [7:0] dispatch,
   output logic [7:0] return_link_file,
   output logic busy
);
   oas_pkg::oas_regs_t r;
   oas_pkg::oas_regs_t next_r;
   logic [15:0] pc_val;
   logic [15:0] x_val;
   logic [15:0] sum;
   logic [7:0] op;
   logic [2:0] mode;
   logic fixed_len;

   assign pc_val = {r.files[oas_pkg::FILE_PU], r.files[oas_pkg::FILE_PL]};
   assign x_val = {r.files[oas_pkg::FILE_XU], r.files[oas_pkg::FILE_XL]};
   assign op = r.files[oas_pkg::FILE_INSTR];
   assign mode = op[2:0];
   // sub op code bit 3 clear marks a fixed two-byte word; set means variable length, one byte here
   assign fixed_len = !op[oas_pkg::WIDTH_BIT];

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      next_r = r;
      sum = 16'h0000;
      next_r.mem.req = 1'b0;
      next_r.mem.wr = 1'b0;
      next_r.irq_ack = 1'b0;
      next_r.cio_strobe = 1'b0;
      case (r.st)
         oas_pkg::OAS_COLD:
         begin
            next_r.files[oas_pkg::FILE_PL] = oas_pkg::COLD_START_PC[7:0];
            next_r.files[oas_pkg::FILE_PU] = oas_pkg::COLD_START_PC[15:8];
            if (boot_switch)
            begin
               next_r.st = oas_pkg::OAS_BOOT;
            end
            else
            begin
               next_r.st = oas_pkg::OAS_FETCH;
            end
         end
         oas_pkg::OAS_BOOT:
         begin
            // load loader from paper tape via serial byte input
            next_r.tape_req = 1'b1;
            next_r.files[oas_pkg::FILE_INSTR] = oas_pkg::OP_SERIAL_IN;
            next_r.files[oas_pkg::FILE_S1] = 8'h00;
            next_r.st = oas_pkg::OAS_NONMEM;
         end
         oas_pkg::OAS_FETCH:
         begin
            if (irq_in.pending)
            begin
               next_r.st = oas_pkg::OAS_IRQ_ACK;
            end
            else
            begin
               next_r.mem.req = 1'b1;
               next_r.mem.addr = pc_val;
               next_r.st = oas_pkg::OAS_FETCH_WAIT;
            end
         end
         oas_pkg::OAS_FETCH_WAIT:
         begin
            next_r.files[oas_pkg::FILE_INSTR] = mem_rdata;
            {next_r.files[oas_pkg::FILE_PU], next_r.files[oas_pkg::FILE_PL]} = pc_val + 16'h0001;
            next_r.st = oas_pkg::OAS_DECODE;
         end
         oas_pkg::OAS_DECODE:
         begin
            // shift right four, mask, main table at 100
            next_r.dispatch = ({4'h0, op[oas_pkg::OP_HI:oas_pkg::OP_LO]} & {4'h0, oas_pkg::MAIN_DISPATCH_BASE[3:0]
               | 4'hF}) | (oas_pkg::MAIN_DISPATCH_BASE & 8'hF0);
            next_r.files[oas_pkg::FILE_S1] = oas_pkg::MAIN_TABLE_LOC[7:0];
            // memory reference picks mode from sub op code
            if (op[oas_pkg::OP_HI:oas_pkg::OP_LO] >= oas_pkg::OP_MEMREF_MIN)
            begin
               next_r.mem.req = 1'b1;
               next_r.mem.addr = pc_val;
               next_r.st = (mode == oas_pkg::MODE_INDEXED) ? oas_pkg::OAS_INDEX :
                  (mode == oas_pkg::MODE_LITERAL) ? oas_pkg::OAS_INDEX : oas_pkg::OAS_BYTE2;
            end
            else
            begin
               next_r.st = oas_pkg::OAS_NONMEM;
            end
         end
         oas_pkg::OAS_IRQ_ACK:
         begin
            next_r.irq_ack = 1'b1;
            next_r.files[oas_pkg::FILE_S2] = irq_in.external ? irq_in.dev_addr : 8'h00;
            next_r.st = irq_in.concurrent ? oas_pkg::OAS_IRQ_CIO : oas_pkg::OAS_IRQ_VEC;
         end
         oas_pkg::OAS_IRQ_VEC:
         begin
            next_r.files[oas_pkg::FILE_PL] = {r.files[oas_pkg::FILE_S2][6:0], 1'b0};
            next_r.files[oas_pkg::FILE_PU] = 8'h00;
            next_r.st = oas_pkg::OAS_FETCH;
         end
         oas_pkg::OAS_IRQ_CIO:
         begin
            next_r.cio_strobe = 1'b1;
            next_r.cio_data = irq_in.data;
            next_r.st = oas_pkg::OAS_FETCH;
         end
         oas_pkg::OAS_BYTE2:
         begin
            // pc still points at the displacement; relative modes add one to pass it
            {next_r.files[oas_pkg::FILE_PU], next_r.files[oas_pkg::FILE_PL]} = pc_val + 16'h0001;
            next_r.files[oas_pkg::FILE_S2] = mem_rdata;
            case (mode)
               oas_pkg::MODE_DIR_PAGE0, oas_pkg::MODE_IND_PAGE0:
               begin
                  sum = {8'h00, mem_rdata};
               end
               oas_pkg::MODE_DIR_REL, oas_pkg::MODE_IND_REL:
               begin
                  sum = pc_val + 16'h0001 + {{8{mem_rdata[7]}}, mem_rdata};
               end
               oas_pkg::MODE_INDEX_BIAS:
               begin
                  sum = x_val + {8'h00, mem_rdata};
               end
               default:
               begin
                  sum = {8'h00, mem_rdata};
               end
            endcase
            {next_r.files[oas_pkg::FILE_OU], next_r.files[oas_pkg::FILE_OL]} = sum;
            if (mode == oas_pkg::MODE_EXTENDED)
            begin
               next_r.mem.req = 1'b1;
               next_r.mem.addr = pc_val + 16'h0001;
               next_r.st = oas_pkg::OAS_BYTE3;
            end
            else if (mode == oas_pkg::MODE_IND_PAGE0 || mode == oas_pkg::MODE_IND_REL)
            begin
               next_r.mem.req = 1'b1;
               next_r.mem.addr = sum;
               next_r.st = oas_pkg::OAS_IND_LO;
            end
            else
            begin
               next_r.st = oas_pkg::OAS_OPER_LO;
               next_r.mem.req = 1'b1;
               next_r.mem.addr = sum;
            end
         end
         oas_pkg::OAS_BYTE3:
         begin
            {next_r.files[oas_pkg::FILE_PU], next_r.files[oas_pkg::FILE_PL]} = pc_val + 16'h0001;
            next_r.indirect = {r.files[oas_pkg::FILE_S2], mem_rdata};
            next_r.st = oas_pkg::OAS_IND_HI;
            next_r.phase = 1'b1;
         end
         oas_pkg::OAS_IND_LO:
         begin
            next_r.indirect[15:8] = mem_rdata;
            next_r.mem.req = 1'b1;
            next_r.mem.addr = {r.files[oas_pkg::FILE_OU], r.files[oas_pkg::FILE_OL]} + 16'h0001;
            next_r.phase = 1'b0;
            next_r.st = oas_pkg::OAS_IND_HI;
         end
         oas_pkg::OAS_IND_HI:
         begin
            if (!r.phase)
            begin
               next_r.indirect[7:0] = mem_rdata;
            end
            sum = r.phase ? r.indirect : {r.indirect[15:8], mem_rdata};
            // extended or indirect word, indexed when bit 15 set
            if (sum[oas_pkg::INDEX_FLAG_BIT])
            begin
               sum = {1'b0, sum[14:0]} + x_val;
            end
            {next_r.files[oas_pkg::FILE_OU], next_r.files[oas_pkg::FILE_OL]} = sum;
            next_r.mem.req = 1'b1;
            next_r.mem.addr = sum;
            next_r.st = oas_pkg::OAS_OPER_LO;
         end
         oas_pkg::OAS_INDEX:
         begin
            if (mode == oas_pkg::MODE_LITERAL)
            begin
               sum = pc_val;
               {next_r.files[oas_pkg::FILE_PU], next_r.files[oas_pkg::FILE_PL]} = pc_val +
                  (fixed_len ? 16'h0002 : 16'h0001);
            end
            else
            begin
               sum = x_val;
            end
            {next_r.files[oas_pkg::FILE_OU], next_r.files[oas_pkg::FILE_OL]} = sum;
            next_r.mem.req = 1'b1;
            next_r.mem.addr = sum;
            next_r.st = oas_pkg::OAS_OPER_LO;
         end
         oas_pkg::OAS_OPER_LO:
         begin
            case (op[oas_pkg::OP_HI:oas_pkg::OP_LO])
               4'hE: next_r.modifier = oas_pkg::COPY_TO_ACC_CODE;
               4'hD: next_r.modifier = oas_pkg::AND_ACC_CODE;
               4'hB: next_r.modifier = oas_pkg::SUB_ACC_CODE;
               4'hA: next_r.modifier = oas_pkg::ADD_ACC_CODE;
               4'h8: next_r.modifier = op[oas_pkg::WIDTH_BIT] ? oas_pkg::STORE_INDEX_CODE
                  : oas_pkg::COPY_TO_INDEX_CODE;
               4'hF: next_r.modifier = oas_pkg::STORE_ACC_CODE;
               default: next_r.modifier = oas_pkg::STORE_EXT_ACC_CODE;
            endcase
            next_r.files[oas_pkg::FILE_S3] = mem_rdata;
            next_r.mem.req = 1'b1;
            next_r.mem.addr = {r.files[oas_pkg::FILE_OU], r.files[oas_pkg::FILE_OL]} + 16'h0001;
            // word length bit clear fetches second byte
            next_r.st = fixed_len ? oas_pkg::OAS_OPER_HI : oas_pkg::OAS_STORE;
         end
         oas_pkg::OAS_OPER_HI:
         begin
            next_r.files[oas_pkg::FILE_S2] = mem_rdata;
            next_r.st = oas_pkg::OAS_STORE;
         end
         oas_pkg::OAS_STORE:
         begin
            // file from modifier low nibble, operation from the whole modifier or its high nibble
            if (r.modifier == oas_pkg::COPY_TO_ACC_CODE)
            begin
               next_r.files[oas_pkg::FILE_AL] = r.files[oas_pkg::FILE_S3];
               if (fixed_len)
               begin
                  next_r.files[oas_pkg::FILE_AU] = r.files[oas_pkg::FILE_S2];
               end
            end
            else if (r.modifier == oas_pkg::COPY_TO_INDEX_CODE)
            begin
               next_r.files[r.modifier[3:0] - 4'h0] = r.files[oas_pkg::FILE_S3];
               next_r.files[oas_pkg::FILE_XU] = r.files[oas_pkg::FILE_S2];
            end
            else if (r.modifier[7:4] == oas_pkg::STORE_ACC_CODE[7:4])
            begin
               next_r.mem.req = 1'b1;
               next_r.mem.wr = 1'b1;
               next_r.mem.addr = {r.files[oas_pkg::FILE_OU], r.files[oas_pkg::FILE_OL]};
               next_r.mem.wdata = r.files[r.modifier[3:0]];
            end
            next_r.filler = 1'b0;
            next_r.st = oas_pkg::OAS_FILLER;
         end
         oas_pkg::OAS_NONMEM:
         begin
            if (op[oas_pkg::OP_HI:oas_pkg::OP_LO] == oas_pkg::OP_SERIAL_IO)
            begin
               next_r.inner = oas_pkg::INNER_COUNT;
               next_r.outer = oas_pkg::OUTER_COUNT;
               next_r.bits = oas_pkg::CHAR_BITS;
               next_r.st = oas_pkg::OAS_SER_INNER;
            end
            else
            begin
               next_r.files[oas_pkg::FILE_S1] = (op[oas_pkg::OP_HI:oas_pkg::OP_LO] == oas_pkg::OP_CONDJ) ?
                  oas_pkg::COND_JUMP_BASE : oas_pkg::CONTROL_DISPATCH_BASE;
               next_r.dispatch = next_r.files[oas_pkg::FILE_S1] + {4'h0, op[3:0]};
               next_r.st = oas_pkg::OAS_RET;
            end
         end
         oas_pkg::OAS_SER_INNER:
         begin
            next_r.inner = r.inner - 8'h01;
            if (r.inner == 8'h01)
            begin
               next_r.st = oas_pkg::OAS_SER_OUTER;
            end
         end
         oas_pkg::OAS_SER_OUTER:
         begin
            next_r.outer = r.outer - 8'h01;
            next_r.inner = oas_pkg::INNER_COUNT;
            next_r.st = (r.outer == 8'h01) ? oas_pkg::OAS_SER_BIT : oas_pkg::OAS_SER_INNER;
         end
         oas_pkg::OAS_SER_BIT:
         begin
            // bits enter low accumulator byte only
            next_r.files[oas_pkg::FILE_AL] = {serial_rx, r.files[oas_pkg::FILE_AL][7:1]};
            // shift file c right, insert one, copy to modifier
            next_r.files[oas_pkg::FILE_S1] = {1'b1, r.files[oas_pkg::FILE_S1][7:1]};
            next_r.modifier = {1'b1, r.files[oas_pkg::FILE_S1][7:1]};
            next_r.bits = r.bits - 4'h1;
            next_r.inner = oas_pkg::INNER_COUNT;
            next_r.outer = oas_pkg::OUTER_COUNT;
            next_r.st = (r.bits == 4'h1) ? oas_pkg::OAS_RET : oas_pkg::OAS_SER_INNER;
         end
         oas_pkg::OAS_FILLER:
         begin
            next_r.filler = 1'b1;
            if (r.filler)
            begin
               next_r.st = oas_pkg::OAS_RET;
            end
         end
         default:
         begin
            next_r.tape_req = 1'b0;
            next_r.st = oas_pkg::OAS_FETCH;
         end
      endcase
      if (cold_start)
      begin
         next_r.st = oas_pkg::OAS_COLD;
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         r <= '0;
      end
      else if (clk_en)
      begin
         r <= next_r;
      end
   end

   assign mem_out = r.mem;
   assign irq_ack = r.irq_ack;
   assign cio_strobe = r.cio_strobe;
   assign cio_data = r.cio_data;
   assign tape_req = r.tape_req;
   assign pc = pc_val;
   assign opaddr = {r.files[oas_pkg::FILE_OU], r.files[oas_pkg::FILE_OL]};
   assign accum = {r.files[oas_pkg::FILE_AU], r.files[oas_pkg::FILE_AL]};
   assign index = x_val;
   assign modifier = r.modifier;
   assign dispatch = r.dispatch;
   assign return_link_file = r.files[oas_pkg::FILE_S1];
   assign busy = (r.st != oas_pkg::OAS_FETCH);
endmodule

// ---- sim/oas_mem_model.sv ----
// oas_mem_model: byte-wide core memory answering the sequencer.
// assumes one-cycle read latency; the bench preloads mem.
module oas_mem_model (
   input wire logic core_clk,
   input wire oas_pkg::oas_mem_req_t mem_out,
   output logic [7:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:65535];
   logic [7:0] last = 8'h00;
   logic rd;
   assign rd = mem_out.req && !mem_out.wr;
   // plain always: the bench preloads mem from its own process
   always @(posedge core_clk)
   begin
      if (mem_out.req && mem_out.wr)
         mem[mem_out.addr] <= mem_out.wdata;
      if (rd)
         last <= mem[mem_out.addr];
   end
   // the request is registered and its byte taken at the next edge, so the read follows it directly;
   // an idle bus shows the inverse, so a late sample never matches by luck
   assign mem_rdata = rd ? mem[mem_out.addr] : ~last;
endmodule

// ---- sim/oas_seq_props.sv ----
// oas_seq_props: interrupt, transfer and bootstrap checks on the sequencer ports.
// assumes it is bound to oas_sequencer and that there is one clock domain.
module oas_seq_props (
   input wire logic core_clk,
   input wire logic nrst,
   input wire oas_pkg::oas_irq_t irq_in,
   input wire logic boot_switch,
   input wire logic irq_ack,
   input wire logic cio_strobe,
   input wire logic [7:0] cio_data,
   input wire logic tape_req,
   input wire logic [15:0] pc,
   input wire logic busy
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   // busy still shows its reset value at the first edge, so wait one edge
   logic up;
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         up <= 1'b0;
      else
         up <= 1'b1;
   end
   sequence s_take;
      up && !busy && irq_in.pending;
   endsequence
   sequence s_vector;
      irq_ack && irq_in.external && !irq_in.concurrent;
   endsequence
   a_take_ack: assert property (s_take |-> ##2 irq_ack)
      else $error("pending interrupt not taken");
   a_ack_cause: assert property ($rose(irq_ack) |-> $past(irq_in.pending))
      else $error("ack without request");
   a_ack_boundary: assert property ($rose(irq_ack) |-> !$past(busy, 2))
      else $error("ack off fetch boundary");
   a_ack_pulse: assert property (irq_ack |=> !irq_ack)
      else $error("ack longer than a cycle");
   a_vector_load: assert property (s_vector |=> pc == {7'h00, $past(irq_in.dev_addr), 1'b0})
      else $error("service address wrong");
   a_cio_byte: assert property (cio_strobe |-> cio_data == $past(irq_in.data))
      else $error("transfer byte wrong");
   a_cio_pulse: assert property (cio_strobe |=> !cio_strobe)
      else $error("strobe longer than a cycle");
   a_boot_switch: assert property ($rose(tape_req) |-> $past(boot_switch, 2))
      else $error("bootstrap without switch");
endmodule
bind oas_sequencer oas_seq_props oas_seq_props_inst (.core_clk(core_clk), .nrst(nrst), .irq_in(irq_in),
   .boot_switch(boot_switch), .irq_ack(irq_ack), .cio_strobe(cio_strobe), .cio_data(cio_data),
   .tape_req(tape_req), .pc(pc), .busy(busy));

// ---- sim/tb.sv ----
// tb: runs short programs through the sequencer and judges its outputs.
// assumes oas_pkg, oas_sequencer, the memory model and the checker come first.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic boot_switch = 1'b0;
   logic serial_rx = 1'b1;
   oas_pkg::oas_irq_t irq_in = '0;
   oas_pkg::oas_mem_req_t mem_out;
   logic [7:0] mem_rdata, cio_data, modifier, link;
   logic irq_ack, cio_strobe, tape_req, busy;
   logic [15:0] pc, opaddr, accum, index;
   int n_mismatch = 0;
   int comparisons = 0;
   always #5 core_clk = ~core_clk;
   oas_sequencer oas_sequencer_inst (.core_clk(core_clk), .nrst(nrst), .clk_en(1'b1), .cold_start(1'b0),
      .boot_switch(boot_switch), .irq_in(irq_in), .mem_rdata(mem_rdata), .serial_rx(serial_rx), .mem_out(mem_out),
      .irq_ack(irq_ack), .cio_strobe(cio_strobe), .cio_data(cio_data), .tape_req(tape_req), .pc(pc),
      .opaddr(opaddr), .accum(accum), .index(index), .modifier(modifier), .dispatch(), .return_link_file(link),
      .busy(busy));
   oas_mem_model oas_mem_model_inst (.core_clk(core_clk), .mem_out(mem_out), .mem_rdata(mem_rdata));
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      if (n_mismatch == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic restart(logic boot);
      @(negedge core_clk);
      nrst = 1'b0;
      boot_switch = boot;
      irq_in = '0;
      repeat (4) @(negedge core_clk);
      nrst = 1'b1;
      // returns in the first fetch state, or the bootstrap state when boot is set, before the first request
      @(negedge core_clk);
   endtask
   task automatic wait_busy(logic lvl);
      int i;
      for (i = 0; i < 400 && busy !== lvl; i++)
         @(negedge core_clk);
      if (busy !== lvl)
      begin
         check("busy", {15'h0000, lvl}, {15'h0000, busy});
         finish_test();
      end
   endtask
   task automatic modes();
      logic [39:0] tbl [9];
      logic [15:0] e;
      tbl = '{40'hE11800001A, 40'hE1F000FFF2, 40'hE09C00009C, 40'hE240001A1B, 40'hE310004849,
         40'hE400000000, 40'hE57F00007F, 40'hE612341234, 40'hE680100010};
      foreach (tbl[i])
      begin
         oas_mem_model_inst.mem[0] = tbl[i][39:32];
         oas_mem_model_inst.mem[1] = tbl[i][31:24];
         oas_mem_model_inst.mem[2] = tbl[i][23:16];
         restart(1'b0);
         wait_busy(1'b0);
         wait_busy(1'b1);
         wait_busy(1'b0);
         e = tbl[i][15:0];
         check("opaddr", e, opaddr);
         check("accum", {oas_mem_model_inst.mem[e + 16'h0001], oas_mem_model_inst.mem[e]}, accum);
      end
   endtask
   task automatic nonmem();
      oas_mem_model_inst.mem[0] = 8'hE0;
      oas_mem_model_inst.mem[1] = 8'h9C;
      oas_mem_model_inst.mem[2] = 8'h40;
      restart(1'b0);
      wait_busy(1'b0);
      repeat (2)
      begin
         wait_busy(1'b1);
         wait_busy(1'b0);
      end
      check("opaddr", 16'h009C, opaddr);
      check("pc", 16'h0003, pc);
   endtask
   task automatic index_chain();
      logic [7:0] prog [7];
      prog = '{8'h80, 8'h20, 8'hE4, 8'hE6, 8'h80, 8'h10, 8'hE7};
      foreach (prog[i])
         oas_mem_model_inst.mem[i] = prog[i];
      restart(1'b0);
      wait_busy(1'b0);
      wait_busy(1'b1);
      wait_busy(1'b0);
      check("index", 16'h7B7A, index);
      wait_busy(1'b1);
      wait_busy(1'b0);
      check("opaddr", 16'h7B7A, opaddr);
      wait_busy(1'b1);
      wait_busy(1'b0);
      check("opaddr", 16'h7B8A, opaddr);
      wait_busy(1'b1);
      wait_busy(1'b0);
      check("opaddr", 16'h0007, opaddr);
      check("pc", 16'h0009, pc);
      check("accum", 16'h525D, accum);
   endtask
   task automatic irq_case(logic conc);
      int i;
      restart(1'b0);
      irq_in = '{1'b1, !conc, conc, 8'h05, 8'hA5};
      for (i = 0; i < 50 && irq_ack !== 1'b1; i++)
         @(negedge core_clk);
      check("irq_ack", 16'h0001, {15'h0000, irq_ack});
      irq_in.pending = 1'b0;
      @(negedge core_clk);
      if (conc)
         check("cio", 16'h01A5, {7'h00, cio_strobe, cio_data});
      else
         check("pc", 16'h000A, pc);
   endtask
   task automatic boot_case();
      int i;
      int bit_time;
      logic [8:0] stream;
      bit_time = int'(oas_pkg::OUTER_COUNT) * (int'(oas_pkg::INNER_COUNT) + 1) + 1;
      stream = {8'hC5, 1'b1};
      restart(1'b1);
      for (i = 0; i < 20 && tape_req !== 1'b1; i++)
         @(negedge core_clk);
      check("tape_req", 16'h0001, {15'h0000, tape_req});
      boot_switch = 1'b0;
      // the line changes half a bit time away from each sampling edge
      for (i = 0; i < 30000 && busy !== 1'b0; i++)
      begin
         serial_rx = stream[(i + bit_time / 2) / bit_time];
         @(negedge core_clk);
      end
      check("busy", 16'h0000, {15'h0000, busy});
      check("accum", 16'h00C5, accum);
      check("link", 16'h00FF, {8'h00, link});
      check("modifier", 16'h00FF, {8'h00, modifier});
   endtask
   initial
   begin
      for (int a = 0; a < 65536; a++)
         oas_mem_model_inst.mem[a] = a[7:0] ^ 8'h5A;
      modes();
      nonmem();
      index_chain();
      irq_case(1'b0);
      irq_case(1'b1);
      boot_case();
      finish_test();
   end
endmodule
